// File: hw/urw_rx_wakeup_match.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// small synchronous fifo with registered pointers

module urw_fifo
#(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // honest flags straight from the fill count
  assign in_ready = (cnt_q != FULL_CNT);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data;
    end
  end

  // pointers wrap at the configured depth, not a power of two
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= (wr_q == LAST_IDX) ? '0 : wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= (rd_q == LAST_IDX) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop)
      begin
        cnt_q <= cnt_q + 1'b1;
      end
      else if (pop && !push)
      begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// receive filter, wakeup, infrared decode and extra-bit handling

module urw_rx_wakeup_match
  import urw_pkg::*;
#(
  parameter int FIFO_DEPTH = URW_FIFO_DEPTH
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [URW_DIV_W-1:0] oversample_div,
  input wire logic [URW_OSR_W-1:0] oversample_ratio_m1,
  input wire logic rxd_pin,
  input wire logic rx_polarity_invert,
  input wire logic infrared_enable,
  input wire logic nine_bit_select,
  input wire logic ten_bit_select,
  input wire logic two_stop_select,
  input wire logic wake_method_select,
  input wire logic idle_count_start_select,
  input wire logic idle_flag_during_sleep,
  input wire logic receiver_sleep_set,
  input wire logic receiver_sleep_clear,
  input wire logic [1:0] match_config,
  input wire logic match_enable_one,
  input wire logic match_enable_two,
  input wire logic [URW_BYTE_W-1:0] match_value_one,
  input wire logic [URW_BYTE_W-1:0] match_value_two,
  input wire logic idle_flag_clear,
  input wire logic overrun_flag_clear,
  input wire logic rx_read,
  input wire logic tx_bit_nine_write,
  input wire logic tx_bit_nine_in,
  input wire logic tx_bit_ten_write,
  input wire logic tx_bit_ten_in,
  input wire logic tx_byte_write,
  input wire logic [URW_BYTE_W-1:0] tx_byte_in,
  input wire logic tx_wide_write,
  input wire logic [URW_CHAR_W-1:0] tx_wide_in,
  input wire logic tx_shifter_take,
  output logic receiver_sleep,
  output logic idle_flag,
  output logic rx_full_flag,
  output logic overrun_flag,
  output logic [URW_CHAR_W-1:0] rx_wide_data,
  output logic rx_bit_nine,
  output logic rx_bit_ten,
  output logic tx_bit_nine,
  output logic tx_bit_ten,
  output logic tx_buf_empty,
  output logic [URW_CHAR_W-1:0] tx_shift_data,
  output logic tx_shift_load
);

  //////////////////////////////////////////////////////////////////////////////
  // oversample tick divider

  logic [URW_DIV_W-1:0] div_q;
  logic os_tick;

  assign os_tick = (div_q == '0);

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      div_q <= '0;
    end
    else
    begin
      div_q <= os_tick ? oversample_div : div_q - 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // infrared decoder, counting on its own after the start edge

  logic line_in;
  logic ir_prev_q;
  logic ir_out_q;
  logic ir_active_q;
  logic ir_late_q;
  logic [URW_OSR_W-1:0] ir_cnt_q;
  logic [URW_OSR_W-1:0] half_cnt;
  logic ir_rise;
  logic ir_fall;

  assign line_in = rxd_pin ^ rx_polarity_invert;
  assign half_cnt = oversample_ratio_m1 >> 1;
  assign ir_rise = !ir_prev_q && line_in;
  assign ir_fall = ir_prev_q && !line_in;

  // only tick samples are seen, so pulses under one tick may vanish
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ir_prev_q <= 1'b1;
      ir_out_q <= 1'b1;
      ir_active_q <= 1'b0;
      ir_late_q <= 1'b0;
      ir_cnt_q <= '0;
    end
    else if (os_tick)
    begin
      ir_prev_q <= line_in;
      if (!ir_active_q)
      begin
        if (ir_fall)
        begin
          ir_active_q <= 1'b1;
          ir_out_q <= 1'b0;
          ir_cnt_q <= '0;
          ir_late_q <= 1'b0;
        end
      end
      else if (ir_rise && (ir_cnt_q >= half_cnt))
      begin
        ir_out_q <= 1'b0;
        ir_cnt_q <= '0;
        ir_late_q <= 1'b0;
      end
      else if (ir_rise && ir_late_q)
      begin
        ir_out_q <= 1'b0;
        ir_cnt_q <= '0;
        ir_late_q <= 1'b0;
      end
      else if (ir_cnt_q == oversample_ratio_m1)
      begin
        // a second silent count rearms for a start edge, unless a pulse begins right now
        ir_active_q <= !ir_out_q || ir_fall;
        ir_out_q <= 1'b1;
        ir_late_q <= 1'b1;
        ir_cnt_q <= '0;
      end
      else
      begin
        ir_cnt_q <= ir_cnt_q + 1'b1;
        if (ir_cnt_q == half_cnt)
        begin
          ir_late_q <= 1'b0;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // frame receiver, single mid-bit sample

  urw_rx_state_t state_q;
  logic rx_line;
  logic rx_prev_q;
  logic [URW_OSR_W-1:0] os_cnt_q;
  logic [3:0] bit_idx_q;
  logic [URW_CHAR_W-1:0] shift_q;
  logic [3:0] n_data;
  logic [3:0] n_stop;
  logic at_mid;
  logic at_end;
  logic char_done;
  logic mark_early;

  assign rx_line = infrared_enable ? ir_out_q : line_in;
  // ten bit select overrides nine
  assign n_data = URW_DATA_BITS_BASE + (ten_bit_select ? 4'h2 : {3'h0, nine_bit_select});
  assign n_stop = URW_STOP_BITS_BASE + {3'h0, two_stop_select};
  assign at_mid = os_tick && (os_cnt_q == half_cnt);
  assign at_end = os_tick && (os_cnt_q == oversample_ratio_m1);
  assign char_done = (state_q == URW_RX_STOP) && at_mid && (bit_idx_q == n_stop - 1'b1);
  // top data bit seen as one at its mid sample, one or two bit times before char_done
  assign mark_early = (state_q == URW_RX_DATA) && at_mid && (bit_idx_q == n_data - 1'b1) && rx_line;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_q <= URW_RX_IDLE;
      rx_prev_q <= 1'b1;
      os_cnt_q <= '0;
      bit_idx_q <= '0;
      shift_q <= '0;
    end
    else if (os_tick)
    begin
      rx_prev_q <= rx_line;
      os_cnt_q <= (os_cnt_q == oversample_ratio_m1) ? '0 : os_cnt_q + 1'b1;
      unique case (state_q)
        URW_RX_IDLE:
        begin
          os_cnt_q <= '0;
          if (rx_prev_q && !rx_line)
          begin
            state_q <= URW_RX_START;
          end
        end
        URW_RX_START:
        begin
          if (at_mid && rx_line)
          begin
            state_q <= URW_RX_IDLE; // glitch, not a start bit
          end
          else if (at_end)
          begin
            state_q <= URW_RX_DATA;
            bit_idx_q <= '0;
            shift_q <= '0; // short characters read zero in the unused upper bits
          end
        end
        URW_RX_DATA:
        begin
          if (at_mid)
          begin
            shift_q[bit_idx_q] <= rx_line;
          end
          if (at_end)
          begin
            bit_idx_q <= (bit_idx_q == n_data - 1'b1) ? '0 : bit_idx_q + 1'b1;
            if (bit_idx_q == n_data - 1'b1)
            begin
              state_q <= URW_RX_STOP;
            end
          end
        end
        URW_RX_STOP:
        begin
          if (char_done)
          begin
            state_q <= URW_RX_IDLE;
          end
          else if (at_end)
          begin
            bit_idx_q <= bit_idx_q + 1'b1;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // idle line detection

  logic [URW_IDLE_W-1:0] idle_cnt_q;
  logic [URW_IDLE_W-1:0] idle_thresh;
  logic idle_armed_q;
  logic idle_hold;
  logic idle_event;

  // start + data + stop, 10 to 13 bit times of oversample ticks
  assign idle_thresh = URW_IDLE_W'(URW_START_BITS + n_data + n_stop) * URW_IDLE_W'({1'b0, oversample_ratio_m1} + 9'h001);
  // with late start nothing of the frame counts before the receiver returns to idle at the last stop bit's mid sample
  assign idle_hold = !rx_line || (idle_count_start_select && (state_q != URW_RX_IDLE));
  assign idle_event = os_tick && !idle_hold && idle_armed_q && (idle_cnt_q == idle_thresh - 1'b1);

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      idle_cnt_q <= '0;
    end
    else if (os_tick)
    begin
      if (idle_hold)
      begin
        idle_cnt_q <= '0;
      end
      else if (idle_cnt_q != idle_thresh)
      begin
        idle_cnt_q <= idle_cnt_q + 1'b1;
      end
    end
  end

  // a long idle line reports once until another character arrives
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      idle_armed_q <= 1'b1;
    end
    else if (char_done)
    begin
      idle_armed_q <= 1'b1;
    end
    else if (idle_event)
    begin
      idle_armed_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // address filtering and wakeup decisions

  logic match_any;
  logic hit_one;
  logic hit_two;
  logic mark_bit;
  logic accept_q;
  logic addr_pending_q;
  logic sleep_q;
  logic store;
  logic data_wake;

  assign match_any = match_enable_one || match_enable_two;
  // compare only against enabled values
  assign hit_one = match_enable_one && (shift_q[URW_BYTE_W-1:0] == match_value_one);
  assign hit_two = match_enable_two && (shift_q[URW_BYTE_W-1:0] == match_value_two);
  assign mark_bit = shift_q[n_data - 1'b1];
  assign data_wake = char_done && sleep_q && (match_config == URW_MCFG_DATA_WAKE) && (hit_one || hit_two);

  // decide whether the finished character reaches the buffer
  always_comb
  begin
    store = 1'b0;
    if (sleep_q)
    begin
      store = data_wake; // character that matched wakes and is kept
    end
    else if (!match_any)
    begin
      store = 1'b1;
    end
    else
    begin
      unique case (match_config)
        URW_MCFG_ADDR_MARK: store = mark_bit ? (hit_one || hit_two) : accept_q;
        URW_MCFG_IDLE_ADDR: store = addr_pending_q ? (hit_one || hit_two) : accept_q;
        URW_MCFG_ON_OFF:
        begin
          if (!(match_enable_one && match_enable_two))
          begin
            store = 1'b1;
          end
          else if (hit_one)
          begin
            store = 1'b1;
          end
          else if (hit_two)
          begin
            store = 1'b0;
          end
          else
          begin
            store = accept_q;
          end
        end
        URW_MCFG_DATA_WAKE: store = 1'b1;
      endcase
    end
  end

  // acceptance window and pending-address state
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      accept_q <= 1'b0;
      addr_pending_q <= 1'b1;
    end
    else
    begin
      if (char_done && !sleep_q && match_any)
      begin
        if (match_config == URW_MCFG_ADDR_MARK && mark_bit)
        begin
          accept_q <= hit_one || hit_two;
        end
        else if (match_config == URW_MCFG_IDLE_ADDR && addr_pending_q)
        begin
          accept_q <= hit_one || hit_two;
        end
        else if (match_config == URW_MCFG_ON_OFF && (hit_one || hit_two))
        begin
          accept_q <= hit_one;
        end
      end
      // idle after the address wins, so the next character is an address again
      if (idle_event)
      begin
        addr_pending_q <= 1'b1;
      end
      else if (char_done && !sleep_q)
      begin
        addr_pending_q <= 1'b0;
      end
    end
  end

  // software sets sleep, hardware wakes; the software set wins a tie
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      sleep_q <= 1'b0;
    end
    else if (receiver_sleep_set)
    begin
      sleep_q <= 1'b1;
    end
    else if (receiver_sleep_clear)
    begin
      sleep_q <= 1'b0;
    end
    else if (sleep_q && !match_any && !wake_method_select && idle_event)
    begin
      sleep_q <= 1'b0;
    end
    else if (sleep_q && !match_any && wake_method_select && mark_early)
    begin
      sleep_q <= 1'b0;
    end
    else if (data_wake)
    begin
      sleep_q <= 1'b0;
    end
  end

  // idle flag, set wins over clear; the waking idle stays silent unless idle_flag_during_sleep is set
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      idle_flag <= 1'b0;
    end
    else if (idle_event && (!sleep_q || idle_flag_during_sleep))
    begin
      idle_flag <= 1'b1;
    end
    else if (idle_flag_clear)
    begin
      idle_flag <= 1'b0;
    end
  end

  assign receiver_sleep = sleep_q;

  //////////////////////////////////////////////////////////////////////////////
  // receive fifo and data window

  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [URW_CHAR_W-1:0] fifo_out_data;

  // the window drains the fifo only when empty or being read
  assign fifo_out_ready = !rx_full_flag || rx_read;

  urw_fifo
  #(
    .WIDTH(URW_CHAR_W),
    .DEPTH(FIFO_DEPTH)
  )
  u_fifo
  (
    .clk(core_clk),
    .rst(rst),
    .in_valid(char_done && store),
    .in_ready(fifo_in_ready),
    .in_data(shift_q),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // extra bits land beside the byte in one wide word
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rx_full_flag <= 1'b0;
      rx_wide_data <= '0;
    end
    else if (fifo_out_ready)
    begin
      rx_full_flag <= fifo_out_valid;
      if (fifo_out_valid)
      begin
        rx_wide_data <= fifo_out_data;
      end
    end
  end

  // a character with nowhere to go is lost and flagged
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      overrun_flag <= 1'b0;
    end
    else if (char_done && store && !fifo_in_ready)
    begin
      overrun_flag <= 1'b1;
    end
    else if (overrun_flag_clear)
    begin
      overrun_flag <= 1'b0;
    end
  end

  assign rx_bit_nine = rx_wide_data[URW_NINE_POS];
  assign rx_bit_ten = rx_wide_data[URW_TEN_POS];

  //////////////////////////////////////////////////////////////////////////////
  // transmit data buffer and extra bits

  logic [URW_BYTE_W-1:0] tx_buf_q;

  // extra bits persist between characters; byte writes reuse them
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      tx_bit_nine <= 1'b0;
      tx_bit_ten <= 1'b0;
    end
    else if (tx_wide_write)
    begin
      tx_bit_nine <= tx_wide_in[URW_NINE_POS];
      tx_bit_ten <= tx_wide_in[URW_TEN_POS];
    end
    else
    begin
      if (tx_bit_nine_write)
      begin
        tx_bit_nine <= tx_bit_nine_in;
      end
      if (tx_bit_ten_write)
      begin
        tx_bit_ten <= tx_bit_ten_in;
      end
    end
  end

  // byte and extras move to the shifter in the same cycle
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      tx_buf_q <= '0;
      tx_buf_empty <= 1'b1;
      tx_shift_data <= '0;
      tx_shift_load <= 1'b0;
    end
    else
    begin
      tx_shift_load <= 1'b0;
      if (tx_shifter_take && !tx_buf_empty)
      begin
        tx_shift_data <= {tx_bit_ten, tx_bit_nine, tx_buf_q};
        tx_shift_load <= 1'b1;
        tx_buf_empty <= 1'b1;
      end
      if (tx_wide_write || tx_byte_write)
      begin
        tx_buf_q <= tx_wide_write ? tx_wide_in[URW_BYTE_W-1:0] : tx_byte_in;
        tx_buf_empty <= 1'b0;
      end
    end
  end

endmodule

// File: pkg/urw_pkg.sv
package urw_pkg;

  // receive framing
  localparam logic [3:0] URW_DATA_BITS_BASE = 4'h8;
  localparam logic [3:0] URW_START_BITS = 4'h1;
  localparam logic [3:0] URW_STOP_BITS_BASE = 4'h1;
  localparam int URW_CHAR_W = 10;
  localparam int URW_BYTE_W = 8;
  localparam int URW_NINE_POS = 8;
  localparam int URW_TEN_POS = 9;

  // oversampling and idle counting widths
  localparam int URW_OSR_W = 8;
  localparam int URW_IDLE_W = 13;
  localparam int URW_DIV_W = 16;
  localparam logic [URW_OSR_W-1:0] URW_OSR_M1_DEF = 8'h0f;

  // receive fifo between the filter and the data window
  localparam int URW_FIFO_DEPTH = 8;

  // match configuration codes
  localparam logic [1:0] URW_MCFG_ADDR_MARK = 2'h0;
  localparam logic [1:0] URW_MCFG_IDLE_ADDR = 2'h1;
  localparam logic [1:0] URW_MCFG_ON_OFF = 2'h2;
  localparam logic [1:0] URW_MCFG_DATA_WAKE = 2'h3;

  // receiver frame states
  typedef enum logic [1:0]
  {
    URW_RX_IDLE = 2'b00,
    URW_RX_START = 2'b01,
    URW_RX_DATA = 2'b10,
    URW_RX_STOP = 2'b11
  } urw_rx_state_t;

endpackage

// File: tb/urw_rx_wakeup_match_props.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// port-level checker for the receive filter and transmit extras
module urw_rx_wakeup_match_props
  import urw_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic idle_flag_during_sleep,
  input wire logic receiver_sleep_set,
  input wire logic idle_flag_clear,
  input wire logic rx_read,
  input wire logic tx_bit_nine_write,
  input wire logic tx_bit_nine_in,
  input wire logic tx_bit_ten_write,
  input wire logic tx_bit_ten_in,
  input wire logic tx_byte_write,
  input wire logic tx_wide_write,
  input wire logic tx_shifter_take,
  input wire logic receiver_sleep,
  input wire logic idle_flag,
  input wire logic rx_full_flag,
  input wire logic [URW_CHAR_W-1:0] rx_wide_data,
  input wire logic rx_bit_nine,
  input wire logic rx_bit_ten,
  input wire logic tx_bit_nine,
  input wire logic tx_bit_ten,
  input wire logic tx_buf_empty,
  input wire logic [URW_CHAR_W-1:0] tx_shift_data,
  input wire logic tx_shift_load
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // software sleep request beats any hardware wake in the same cycle
  AST_SLEEP_SET: assert property (receiver_sleep_set |=> receiver_sleep)
    else $error("sleep request lost");
  AST_IDLE_QUIET: assert property ($rose(idle_flag) |-> !$past(receiver_sleep) || $past(idle_flag_during_sleep))
    else $error("idle flag set while sleeping");
  AST_IDLE_STICKY: assert property (idle_flag && !idle_flag_clear |=> idle_flag)
    else $error("idle flag dropped without clear");
  // window must not move under software until it is read
  AST_WINDOW_HOLD: assert property (rx_full_flag && !rx_read |=> rx_full_flag && $stable(rx_wide_data))
    else $error("receive window changed unread");
  AST_RX_EXTRAS: assert property (rx_bit_nine == rx_wide_data[8] && rx_bit_ten == rx_wide_data[9])
    else $error("rx extra bits differ from window");
  AST_NINE_WRITE: assert property (tx_bit_nine_write && !tx_wide_write |=> tx_bit_nine == $past(tx_bit_nine_in))
    else $error("tx ninth bit not written");
  AST_TEN_WRITE: assert property (tx_bit_ten_write && !tx_wide_write |=> tx_bit_ten == $past(tx_bit_ten_in))
    else $error("tx tenth bit not written");
  AST_EMPTY_ON_WRITE: assert property (tx_byte_write || tx_wide_write |=> !tx_buf_empty)
    else $error("tx buffer still empty after write");
  AST_LOAD_CAUSE: assert property (tx_shift_load |-> $past(tx_shifter_take) && !$past(tx_buf_empty))
    else $error("shifter load without a full buffer");
  // writes in the take cycle are excluded, though the shifter still gets the extras held before the write
  AST_LOAD_EXTRAS: assert property (tx_shifter_take && !tx_buf_empty && !tx_bit_nine_write && !tx_bit_ten_write
    && !tx_wide_write && !tx_byte_write |=> tx_shift_load
    && tx_shift_data[9:8] == {$past(tx_bit_ten), $past(tx_bit_nine)})
    else $error("extra bits not moved with the byte");

  COV_LOAD: cover property (tx_shift_load);
  COV_WAKE: cover property ($fell(receiver_sleep));
  COV_IDLE: cover property ($rose(idle_flag));
endmodule

bind urw_rx_wakeup_match urw_rx_wakeup_match_props chk (.*);

// File: tb/urw_line_model.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// far serial node; the line rests at mark level as on a pulled-up wire
module urw_line_model
#(
  parameter int BIT_CYC = 8
)
(
  input wire logic clk,
  output logic line
);
  initial line = 1'b1;

  // start, data lsb first, stops; infrared sends a one-tick low pulse per zero
  task automatic send(input logic [9:0] w, input int nb, input int ns, input bit ir);
    logic b;
    for (int i = 0; i < 1 + nb + ns; i++)
    begin
      b = (i == 0) ? 1'b0 : (i <= nb) ? w[i-1] : 1'b1;
      for (int t = 0; t < BIT_CYC; t++)
      begin
        @(posedge clk);
        #1 line = b | (ir && t > 0);
      end
    end
  endtask
endmodule

// File: tb/urw_rx_wakeup_match_tb.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module urw_rx_wakeup_match_tb
  import urw_pkg::*;
;
  logic core_clk = 1'b0, rst = 1'b1, rx_polarity_invert = 1'b0, infrared_enable = 1'b0, rxd_pin;
  logic nine_bit_select = 1'b0, ten_bit_select = 1'b0, two_stop_select = 1'b0, wake_method_select = 1'b0;
  logic idle_count_start_select = 1'b0, idle_flag_during_sleep = 1'b0, receiver_sleep_set = 1'b0;
  logic receiver_sleep_clear = 1'b0, match_enable_one = 1'b0, match_enable_two = 1'b0, idle_flag_clear = 1'b0;
  logic overrun_flag_clear = 1'b0, rx_read = 1'b0, tx_bit_nine_write = 1'b0, tx_bit_nine_in = 1'b0;
  logic tx_bit_ten_write = 1'b0, tx_bit_ten_in = 1'b0, tx_byte_write = 1'b0, tx_wide_write = 1'b0;
  logic tx_shifter_take = 1'b0, tx_buf_empty, tx_shift_load;
  logic [URW_DIV_W-1:0] oversample_div = 16'h0000;
  logic [URW_OSR_W-1:0] oversample_ratio_m1 = 8'h07;
  logic [1:0] match_config = 2'h0;
  logic [URW_BYTE_W-1:0] match_value_one = 8'h00, match_value_two = 8'h00, tx_byte_in = 8'h00;
  logic [URW_CHAR_W-1:0] tx_wide_in = 10'h000, rx_wide_data, tx_shift_data;
  logic receiver_sleep, idle_flag, rx_full_flag, overrun_flag, rx_bit_nine, rx_bit_ten, tx_bit_nine, tx_bit_ten;
  logic [31:0] seed = 32'hbc6e, r;
  logic [7:0] q [$];
  int nbits = 8, num_errors = 0, num_checks = 0;
  bit acc = 1'b0, new_msg = 1'b0;

  urw_rx_wakeup_match uut (.*);
  urw_line_model peer (.clk(core_clk), .line(rxd_pin));

  initial
  begin
    forever #2.5 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // expected filter verdict, tracking acceptance the way the receiver should
  function automatic bit keep(input logic [7:0] b);
    bit hit;
    hit = (match_enable_one && b == match_value_one) || (match_enable_two && b == match_value_two);
    if ((!match_enable_one && !match_enable_two) || match_config == URW_MCFG_DATA_WAKE)
      return 1'b1;
    if ((match_config == URW_MCFG_ADDR_MARK && b[7]) || (match_config == URW_MCFG_IDLE_ADDR && new_msg))
      acc = hit;
    if (match_config == URW_MCFG_ON_OFF)
      acc = (b == match_value_one) ? 1'b1 : (b == match_value_two) ? 1'b0 : acc;
    new_msg = 1'b0;
    return acc;
  endfunction

  task automatic chk(input string name, input logic [9:0] seen, input logic [9:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic pulse(ref logic s);
    @(posedge core_clk);
    #1 s = 1'b1;
    @(posedge core_clk);
    #1 s = 1'b0;
  endtask

  // one character on the line, then the window is judged and consumed
  task automatic xfer(input logic [9:0] w, input bit exp_keep);
    peer.send(w, nbits, 1 + two_stop_select, infrared_enable);
    repeat (6) @(posedge core_clk);
    #1 chk("rx_full_flag", {9'h0, rx_full_flag}, {9'h0, exp_keep});
    if (exp_keep)
    begin
      chk("rx_wide_data", rx_wide_data, w);
      chk("rx_extras", {8'h0, rx_bit_ten, rx_bit_nine}, {8'h0, w[9:8]});
      pulse(rx_read);
    end
  endtask

  task automatic run(input logic [7:0] s [8], input int two_from);
    for (int i = 0; i < 8; i++)
    begin
      match_enable_two = (i >= two_from);
      xfer({2'b00, s[i]}, keep(s[i]));
    end
  endtask

  // idle longer than the longest frame, then the idle flag is judged and cleared
  task automatic gap(input bit exp);
    repeat (120) @(posedge core_clk);
    #1 new_msg = 1'b1;
    chk("idle_flag", {9'h0, idle_flag}, {9'h0, exp});
    pulse(idle_flag_clear);
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // whole run is near 6k cycles; this leaves over six times that
  initial
  begin
    #200000;
    num_errors++;
    $display("ERROR watchdog expected finish seen hang");
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge core_clk);
    #1 rst = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      r = xs();
      xfer({2'b00, r[7:0]}, keep(r[7:0]));
    end
    // overfill the fifo while software stalls, then drain in order
    for (int i = 0; i < 10; i++)
    begin
      r = xs();
      q.push_back(r[7:0]);
      peer.send({2'b00, r[7:0]}, 8, 1, 1'b0);
    end
    repeat (6) @(posedge core_clk);
    #1 chk("overrun_flag", {9'h0, overrun_flag}, 10'h001);
    for (int i = 0; i < 8; i++)
    begin
      chk("fifo_order", rx_wide_data, {2'b00, q[i]});
      pulse(rx_read);
      @(posedge core_clk);
      #1;
    end
    while (rx_full_flag === 1'b1)
    begin
      pulse(rx_read);
      @(posedge core_clk);
      #1;
    end
    pulse(overrun_flag_clear);
    chk("overrun_flag", {9'h0, overrun_flag}, 10'h000);
    match_value_one = 8'h81;
    match_value_two = 8'h82;
    match_enable_one = 1'b1;
    run('{8'h82, 8'h11, 8'h81, 8'h22, 8'h82, 8'h82, 8'h44, 8'h81}, 5);
    match_config = URW_MCFG_ON_OFF;
    run('{8'h82, 8'h33, 8'h81, 8'h44, 8'h82, 8'h55, 8'h81, 8'h66}, 0);
    match_config = URW_MCFG_IDLE_ADDR;
    gap(1'b1);
    run('{8'h81, 8'h23, 8'h82, 8'h45, 8'h67, 8'h89, 8'h0a, 8'hbc}, 8);
    gap(1'b1);
    run('{8'h99, 8'h81, 8'h23, 8'h45, 8'h67, 8'h89, 8'h0a, 8'hbc}, 8);
    match_enable_one = 1'b0;
    match_config = URW_MCFG_ADDR_MARK;
    for (int k = 0; k < 2; k++)
    begin
      idle_flag_during_sleep = (k == 1);
      idle_count_start_select = (k == 1);
      pulse(receiver_sleep_set);
      xfer(10'h03c, 1'b0);
      chk("receiver_sleep", {9'h0, receiver_sleep}, 10'h001);
      gap(k == 1);
      chk("receiver_sleep", {9'h0, receiver_sleep}, 10'h000);
      xfer(10'h05a, 1'b1);
    end
    wake_method_select = 1'b1;
    pulse(receiver_sleep_set);
    xfer(10'h012, 1'b0);
    xfer(10'h09a, 1'b1);
    chk("receiver_sleep", {9'h0, receiver_sleep}, 10'h000);
    wake_method_select = 1'b0;
    match_config = URW_MCFG_DATA_WAKE;
    match_value_one = 8'h5a;
    match_enable_one = 1'b1;
    pulse(receiver_sleep_set);
    xfer(10'h011, 1'b0);
    xfer(10'h05a, 1'b1);
    chk("receiver_sleep", {9'h0, receiver_sleep}, 10'h000);
    pulse(receiver_sleep_set);
    pulse(receiver_sleep_clear);
    chk("receiver_sleep", {9'h0, receiver_sleep}, 10'h000);
    match_enable_one = 1'b0;
    ten_bit_select = 1'b1;
    two_stop_select = 1'b1;
    nbits = 10;
    for (int i = 0; i < 3; i++)
    begin
      r = xs();
      xfer(r[9:0], 1'b1);
    end
    ten_bit_select = 1'b0;
    two_stop_select = 1'b0;
    nbits = 8;
    infrared_enable = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      r = (i == 0) ? 32'h0 : (i == 1) ? 32'hff : xs();
      xfer({2'b00, r[7:0]}, 1'b1);
    end
    infrared_enable = 1'b0;
    // extras written once, reused by two byte writes, then rewritten by a wide write
    tx_bit_nine_in = 1'b1;
    pulse(tx_bit_nine_write);
    pulse(tx_bit_ten_write);
    for (int i = 0; i < 3; i++)
    begin
      r = xs();
      tx_byte_in = r[7:0];
      tx_wide_in = {2'b01, r[7:0]};
      if (i == 2)
        pulse(tx_wide_write);
      else
        pulse(tx_byte_write);
      chk("tx_buf_empty", {9'h0, tx_buf_empty}, 10'h000);
      pulse(tx_shifter_take);
      chk("tx_shift_load", {9'h0, tx_shift_load}, 10'h001);
      chk("tx_shift_data", tx_shift_data, {2'b01, r[7:0]});
    end
    report_and_stop();
  end
endmodule
